// [design/rdc_defines.vh]
// Register map, field positions, reset values and constants of the receiver configuration bank.
`ifndef RDC_DEFINES_VH
`define RDC_DEFINES_VH
// Register offsets.
`define RDC_OFF_IF_CHF        8'h02
`define RDC_OFF_RATE_CONV     8'h03
`define RDC_OFF_ATH_METHOD    8'h06
`define RDC_OFF_AFC_LIMIT     8'h07
`define RDC_OFF_AFC_FREEZE    8'h08
`define RDC_OFF_LO_HIGH       8'h09
`define RDC_OFF_LO_MID        8'h0a
`define RDC_OFF_LO_LOW        8'h0b
`define RDC_OFF_SYNC_LEN      8'h0c
`define RDC_OFF_SYNC_LOW      8'h0d
`define RDC_OFF_SYNC_HIGH     8'h0e
`define RDC_OFF_SIGNAL_STRENGTH          8'h10
`define RDC_OFF_FREQ_ERR      8'h11
`define RDC_OFF_DEMOD_FILT    8'h12
`define RDC_OFF_IRQ_STATUS    8'h13
// Field positions.
`define RDC_BIT_ASK_FSK       4
`define RDC_BIT_IF_SEL        3
`define RDC_BIT_ATH_METHOD    6
`define RDC_BIT_THRESHOLD_FILTER_BANDWIDTH        5
`define RDC_BIT_FREEZE        6
`define RDC_BIT_SYNC_DET      0
// Writable bit masks; every other bit reads zero.
`define RDC_MASK_IF_CHF       8'h1f
`define RDC_MASK_RATE_CONV    8'hff
`define RDC_MASK_ATH_METHOD   8'h7f
`define RDC_MASK_AFC_LIMIT    8'h1f
`define RDC_MASK_AFC_FREEZE   8'h7f
`define RDC_MASK_SYNC_LEN     8'h0f
// Reset values.
`define RDC_RST_IF_CHF        8'h00
`define RDC_RST_RATE_CONV     8'h10
`define RDC_RST_ATH_METHOD    8'h0f
`define RDC_RST_AFC_LIMIT     8'h02
`define RDC_RST_AFC_FREEZE    8'h00
`define RDC_RST_LO_HIGH       8'h13
`define RDC_RST_LO_MID        8'ha9
`define RDC_RST_LO_LOW        8'h9a
`define RDC_RST_SYNC_LEN      8'h0f
`define RDC_RST_SYNC_WORD     8'h00
`define RDC_RST_READING       8'h00
// Frequency control: full-scale correction in synthesizer steps.
`define RDC_AFC_MAX_OFFSET    16'd1792
`define RDC_AFC_STEPS         16'd7
// Serial slave address, arbitrary value.
`define RDC_I2C_ADDR          7'h2a
`endif

// [design/rdc_i2c_slave.v]
// Serial two-wire slave that turns bus transfers into register read and write strobes.
`timescale 1ns/1ps
`include "rdc_defines.vh"
module rdc_i2c_slave (
  // Clock and reset.
  input  wire       clk,
  input  wire       srst,
  // Bus pins.
  input  wire       scl,
  input  wire       sda_in,
  output reg        sda_oe,
  // Register side.
  output reg        wr_en,
  output reg  [7:0] wr_addr,
  output reg  [7:0] wr_data,
  output reg        rd_en,
  output reg  [7:0] ptr,
  input  wire [7:0] rdata
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK  = 3'd2;
  localparam ST_WR   = 3'd3;
  localparam ST_RD   = 3'd4;
  localparam ST_RACK = 3'd5;

  reg       scl_q;    // Previous clock level.
  reg       sda_q;    // Previous data level.
  reg [2:0] st;       // Transfer state.
  reg [3:0] cnt;      // Bits moved in the current byte.
  reg [7:0] shreg;    // Byte shifter.
  reg       rw;       // High for a read transfer.
  reg       first;    // Next written byte is the register pointer.

  wire rise  = scl & ~scl_q;
  wire fall  = ~scl & scl_q;
  wire start = scl & scl_q & sda_q & ~sda_in;
  wire stop  = scl & scl_q & ~sda_q & sda_in;

  // Byte engine: start and stop win over any bit activity.
  always @(posedge clk) begin
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      sda_oe <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      ptr <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      if (start) begin
        st <= ST_ADDR;
        cnt <= 4'h0;
        first <= 1'b1;
        sda_oe <= 1'b0;
      end else if (stop) begin
        st <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st)
          ST_ADDR, ST_WR: begin
            if (rise) begin
              shreg <= {shreg[6:0], sda_in};
              cnt <= cnt + 4'h1;
            end else if (fall && cnt == 4'h8) begin
              cnt <= 4'h0;
              if (st == ST_ADDR) begin
                // Only our own address is acknowledged.
                if (shreg[7:1] == `RDC_I2C_ADDR) begin
                  st <= ST_ACK;
                  rw <= shreg[0];
                  sda_oe <= 1'b1;
                end else begin
                  st <= ST_IDLE;
                end
              end else begin
                st <= ST_ACK;
                sda_oe <= 1'b1;
                if (first) begin
                  ptr <= shreg;
                  first <= 1'b0;
                end else begin
                  wr_en <= 1'b1;
                  wr_addr <= ptr;
                  wr_data <= shreg;
                  ptr <= ptr + 8'h01;
                end
              end
            end
          end
          ST_ACK: begin
            if (fall) begin
              cnt <= 4'h0;
              if (rw) begin
                // Fetch the byte at the pointer and drive its top bit.
                st <= ST_RD;
                shreg <= rdata;
                sda_oe <= ~rdata[7];
                rd_en <= 1'b1;
                ptr <= ptr + 8'h01;
              end else begin
                st <= ST_WR;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_RD: begin
            if (fall) begin
              cnt <= cnt + 4'h1;
              if (cnt == 4'h7) begin
                st <= ST_RACK;
                sda_oe <= 1'b0;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
              end
            end
          end
          ST_RACK: begin
            // A master acknowledge asks for another byte, a refusal ends the read.
            if (rise) begin
              st <= sda_in ? ST_IDLE : ST_ACK;
            end
          end
          default: begin
            st <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// [design/rdc_sync_detect.v]
// Manchester decoder with a programmable-length sync pattern comparator.
`timescale 1ns/1ps
module rdc_sync_detect (
  // Clock and reset.
  input  wire        clk,
  input  wire        srst,
  // Demodulated chips, two per data bit.
  input  wire        chip,
  input  wire        chip_valid,
  // Pattern settings.
  input  wire [3:0]  pat_len,
  input  wire [15:0] pat_word,
  // Detection pulse.
  output reg         match
);
  reg        half;     // High when the first chip of a pair is held.
  reg        first;    // First chip of the pair.
  reg [15:0] sr;       // Decoded bits, newest at bit 0.
  reg [4:0]  seen;     // Decoded bits gathered, saturating at 16.

  // Mask with the low len+1 bits set.
  function [15:0] len_mask;
    input [3:0] len;
    begin
      len_mask = 16'hffff >> (4'hf - len);
    end
  endfunction

  wire [15:0] mask  = len_mask(pat_len);
  wire        bit_v = chip_valid & half & (first != chip);

  // Pairs 1-0 decode to one and 0-1 to zero; equal chips resync the pairing.
  always @(posedge clk) begin
    if (srst) begin
      half <= 1'b0;
      first <= 1'b0;
      sr <= 16'h0000;
      seen <= 5'd0;
      match <= 1'b0;
    end else begin
      match <= 1'b0;
      if (chip_valid) begin
        if (!half || first == chip) begin
          first <= chip;
          half <= 1'b1;
        end else begin
          half <= 1'b0;
        end
      end
      if (bit_v) begin
        sr <= {sr[14:0], first};
        if (seen != 5'd16) begin
          seen <= seen + 5'd1;
        end
        // Compare on the decoded bits, not the line chips.
        if (((({sr[14:0], first}) ^ pat_word) & mask) == 16'h0000 &&
            seen >= {1'b0, pat_len}) begin
          match <= 1'b1;
        end
      end
    end
  end
endmodule

// [design/rdc_config_bank.v]
// Configuration and status register bank of the receiver digital section.
// Function
// - Bit 6 picks lowpass or peak slicing.
// - Bit 5 doubles lowpass threshold filter bandwidth.
// - Offset limit zero disables, else n/7.
// - Loop gain quarter, half, default, double.
// - Freeze holds synthesizer after sync, FSK only.
// - Center frequency 24 bits, high byte first.
// - Pattern length is field plus one.
// - Pattern word low byte first, reset zero.
// - Pattern compared after Manchester decoding.
// - Signal strength unsigned read-only, reset zero.
// - Frequency error signed read-only, reset zero.
// - Filter readout signed read-only, reset zero.
// - IF select bit: 400kHz clear, 200kHz set.
// - Coarse rate field scales four times downward.
// - Status bit 0 flags sync in polling.
`timescale 1ns/1ps
`include "rdc_defines.vh"
module rdc_config_bank (
  // Clock and reset.
  input  wire        clk,
  input  wire        srst,
  // Serial bus pins; data pin is open drain, output level always low.
  input  wire        scl,
  input  wire        sda_in,
  output reg         sda_out,
  output wire        sda_oe,
  // Live readings from the receive chain.
  input  wire [7:0]  signal_strength_in,
  input  wire [7:0]  freq_err_in,
  input  wire        freq_err_valid,
  input  wire [7:0]  demod_filt_in,
  // Demodulated chips and receiver mode.
  input  wire        chip,
  input  wire        chip_valid,
  input  wire        self_poll_active,
  input  wire        rx_restart,
  // Configuration outputs.
  output reg         fsk_mode,
  output reg         if_low_select,
  output reg  [2:0]  channel_filter_choice,
  output reg  [2:0]  rate_converter_coarse,
  output reg  [2:0]  rate_converter_fine,
  output reg         threshold_method_select,
  output reg         threshold_filter_bandwidth,
  output reg  [4:0]  threshold_gain_param,
  output reg  [2:0]  freq_offset_limit,
  output reg  [1:0]  freq_loop_gain,
  output reg         freeze_on_sync_detect,
  output reg  [23:0] osc_center_freq_word,
  output reg  [3:0]  sync_pattern_len,
  output reg  [15:0] sync_pattern_word,
  // Derived outputs.
  output reg         afc_enable,
  output reg         afc_frozen,
  output reg  [15:0] afc_correction,
  output reg  [23:0] synth_freq_word,
  output reg         sync_detected_flag
);
  reg  [5:0]  afc_reserved;        // Reserved low bits of the freeze register.
  reg  [1:0]  rate_conv_top;       // Upper bits of the rate converter register.
  reg  [7:0]  signal_strength;     // Latest strength reading.
  reg  [7:0]  freq_error_value;    // Latest frequency error estimate.
  reg  [7:0]  demod_filter_value;  // Latest post-demodulation filter output.
  reg         sync_seen;           // Sync found since the last restart.
  reg  [7:0]  rdata;               // Read data for the slave.
  reg  [15:0] next_corr;           // Correction after one loop step.
  wire        wr_en;               // Register write strobe.
  wire [7:0]  wr_addr;             // Register write address.
  wire [7:0]  wr_data;             // Register write data.
  wire        rd_en;               // Register read strobe.
  wire [7:0]  ptr;                 // Register pointer.
  wire        sync_match;          // One-cycle sync pattern match.

  // Signed byte scaled by the loop gain setting.
  function [15:0] gain_scale;
    input [7:0] err;
    input [1:0] g;
    reg   [15:0] ext;
    begin
      ext = {{8{err[7]}}, err};
      case (g)
        2'd0:    gain_scale = {{2{ext[15]}}, ext[15:2]};
        2'd1:    gain_scale = {ext[15], ext[15:1]};
        2'd2:    gain_scale = ext;
        default: gain_scale = {ext[14:0], 1'b0};
      endcase
    end
  endfunction

  // Correction bound as n sevenths of full scale.
  function [15:0] afc_bound;
    input [2:0] n;
    reg   [18:0] prod;
    begin
      prod = `RDC_AFC_MAX_OFFSET * n;
      afc_bound = prod[15:0] / `RDC_AFC_STEPS;
    end
  endfunction

  // Reset bytes as parameters, so that single fields can be taken from them.
  localparam [7:0] RST_IF  = `RDC_RST_IF_CHF;
  localparam [7:0] RST_ATH = `RDC_RST_ATH_METHOD;
  localparam [7:0] RST_AFC = `RDC_RST_AFC_LIMIT;
  localparam [7:0] RST_FRZ = `RDC_RST_AFC_FREEZE;
  localparam [7:0] RST_LEN = `RDC_RST_SYNC_LEN;

  rdc_i2c_slave u_slave (
    .clk     (clk),
    .srst    (srst),
    .scl     (scl),
    .sda_in  (sda_in),
    .sda_oe  (sda_oe),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_en   (rd_en),
    .ptr     (ptr),
    .rdata   (rdata)
  );

  rdc_sync_detect u_sync (
    .clk        (clk),
    .srst       (srst),
    .chip       (chip),
    .chip_valid (chip_valid),
    .pat_len    (sync_pattern_len),
    .pat_word   (sync_pattern_word),
    .match      (sync_match)
  );

  // Writable registers; read-only addresses and unmapped ones take no write.
  always @(posedge clk) begin
    if (srst) begin
      sda_out <= 1'b0;
      {fsk_mode, if_low_select, channel_filter_choice} <= RST_IF[4:0];
      {rate_conv_top, rate_converter_coarse, rate_converter_fine} <= `RDC_RST_RATE_CONV;
      {threshold_method_select, threshold_filter_bandwidth, threshold_gain_param} <= RST_ATH[6:0];
      {freq_offset_limit, freq_loop_gain} <= RST_AFC[4:0];
      {freeze_on_sync_detect, afc_reserved} <= RST_FRZ[6:0];
      osc_center_freq_word <= {`RDC_RST_LO_HIGH, `RDC_RST_LO_MID, `RDC_RST_LO_LOW};
      sync_pattern_len <= RST_LEN[3:0];
      sync_pattern_word <= {`RDC_RST_SYNC_WORD, `RDC_RST_SYNC_WORD};
    end else if (wr_en) begin
      case (wr_addr)
        `RDC_OFF_IF_CHF: begin
          // Bit 3 chooses the intermediate frequency; 1 means 200kHz.
          {fsk_mode, if_low_select, channel_filter_choice} <= wr_data[4:0];
        end
        `RDC_OFF_RATE_CONV: begin
          {rate_conv_top, rate_converter_coarse, rate_converter_fine} <= wr_data;
        end
        `RDC_OFF_ATH_METHOD: begin
          threshold_method_select <= wr_data[`RDC_BIT_ATH_METHOD];
          threshold_filter_bandwidth <= wr_data[`RDC_BIT_THRESHOLD_FILTER_BANDWIDTH];
          threshold_gain_param <= wr_data[4:0];
        end
        `RDC_OFF_AFC_LIMIT: begin
          {freq_offset_limit, freq_loop_gain} <= wr_data[4:0];
        end
        `RDC_OFF_AFC_FREEZE: begin
          {freeze_on_sync_detect, afc_reserved} <= wr_data[6:0];
        end
        `RDC_OFF_LO_HIGH: begin
          osc_center_freq_word[23:16] <= wr_data;
        end
        `RDC_OFF_LO_MID: begin
          osc_center_freq_word[15:8] <= wr_data;
        end
        `RDC_OFF_LO_LOW: begin
          osc_center_freq_word[7:0] <= wr_data;
        end
        `RDC_OFF_SYNC_LEN: begin
          sync_pattern_len <= wr_data[3:0];
        end
        `RDC_OFF_SYNC_LOW: begin
          sync_pattern_word[7:0] <= wr_data;
        end
        `RDC_OFF_SYNC_HIGH: begin
          sync_pattern_word[15:8] <= wr_data;
        end
        default: begin
          // Read-only and unmapped addresses keep their contents.
          sync_pattern_len <= sync_pattern_len;
        end
      endcase
    end
  end

  // Live readings are sampled every cycle; the error estimate on its strobe.
  always @(posedge clk) begin
    if (srst) begin
      signal_strength <= `RDC_RST_READING;
      freq_error_value <= `RDC_RST_READING;
      demod_filter_value <= `RDC_RST_READING;
    end else begin
      signal_strength <= signal_strength_in;
      demod_filter_value <= demod_filt_in;
      if (freq_err_valid) begin
        freq_error_value <= freq_err_in;
      end
    end
  end

  // Sync status: detection in polling sets it, reading clears it, set wins.
  always @(posedge clk) begin
    if (srst) begin
      sync_detected_flag <= 1'b0;
      sync_seen <= 1'b0;
    end else begin
      if (sync_match && self_poll_active) begin
        sync_detected_flag <= 1'b1;
      end else if (rd_en && ptr == `RDC_OFF_IRQ_STATUS + 8'h01) begin // Pointer already stepped past it.
        sync_detected_flag <= 1'b0;
      end
      if (sync_match) begin
        sync_seen <= 1'b1;
      end else if (rx_restart) begin
        sync_seen <= 1'b0;
      end
    end
  end

  // One loop step: scaled error added, then bounded to the offset limit.
  always @* begin
    next_corr = afc_correction + gain_scale(freq_err_in, freq_loop_gain);
    if (!next_corr[15] && next_corr > afc_bound(freq_offset_limit)) begin
      next_corr = afc_bound(freq_offset_limit);
    end else if (next_corr[15] && (16'h0000 - next_corr) > afc_bound(freq_offset_limit)) begin
      next_corr = 16'h0000 - afc_bound(freq_offset_limit);
    end
  end

  // Frequency loop; freezing holds the synthesizer word, and only in FSK.
  always @(posedge clk) begin
    if (srst) begin
      afc_enable <= 1'b0;
      afc_frozen <= 1'b0;
      afc_correction <= 16'h0000;
      synth_freq_word <= {`RDC_RST_LO_HIGH, `RDC_RST_LO_MID, `RDC_RST_LO_LOW};
    end else begin
      afc_enable <= (freq_offset_limit != 3'd0);
      afc_frozen <= fsk_mode & freeze_on_sync_detect & (sync_seen | sync_match);
      if (freq_offset_limit == 3'd0) begin
        afc_correction <= 16'h0000;
      end else if (freq_err_valid && !afc_frozen) begin
        afc_correction <= next_corr;
      end
      if (!afc_frozen) begin
        synth_freq_word <= osc_center_freq_word + {{8{afc_correction[15]}}, afc_correction};
      end
    end
  end

  // Read data at the pointer; unused bits and unmapped addresses read zero.
  always @* begin
    case (ptr)
      `RDC_OFF_IF_CHF:     rdata = {3'b000, fsk_mode, if_low_select, channel_filter_choice};
      `RDC_OFF_RATE_CONV:  rdata = {rate_conv_top, rate_converter_coarse, rate_converter_fine};
      `RDC_OFF_ATH_METHOD: rdata = {1'b0, threshold_method_select, threshold_filter_bandwidth,
                                    threshold_gain_param};
      `RDC_OFF_AFC_LIMIT:  rdata = {3'b000, freq_offset_limit, freq_loop_gain};
      `RDC_OFF_AFC_FREEZE: rdata = {1'b0, freeze_on_sync_detect, afc_reserved};
      `RDC_OFF_LO_HIGH:    rdata = osc_center_freq_word[23:16];
      `RDC_OFF_LO_MID:     rdata = osc_center_freq_word[15:8];
      `RDC_OFF_LO_LOW:     rdata = osc_center_freq_word[7:0];
      `RDC_OFF_SYNC_LEN:   rdata = {4'h0, sync_pattern_len};
      `RDC_OFF_SYNC_LOW:   rdata = sync_pattern_word[7:0];
      `RDC_OFF_SYNC_HIGH:  rdata = sync_pattern_word[15:8];
      `RDC_OFF_SIGNAL_STRENGTH:       rdata = signal_strength;
      `RDC_OFF_FREQ_ERR:   rdata = freq_error_value;
      `RDC_OFF_DEMOD_FILT: rdata = demod_filter_value;
      `RDC_OFF_IRQ_STATUS: rdata = {7'h00, sync_detected_flag};
      default:             rdata = 8'h00;
    endcase
  end
endmodule

// [tb/rdc_config_bank_assertions.sv]
// Concurrent checks on the ports of the receiver configuration bank.
`timescale 1ns/1ps
module rdc_config_bank_assertions (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        srst,
  // Bus and receiver inputs.
  input wire logic        scl,
  input wire logic        freq_err_valid,
  input wire logic        self_poll_active,
  // Observed outputs.
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        fsk_mode,
  input wire logic        freeze_on_sync_detect,
  input wire logic [2:0]  freq_offset_limit,
  input wire logic [23:0] osc_center_freq_word,
  input wire logic        afc_enable,
  input wire logic        afc_frozen,
  input wire logic [15:0] afc_correction,
  input wire logic [23:0] synth_freq_word,
  input wire logic        sync_detected_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Correction bound: the limit field times one seventh of full scale.
  wire signed [16:0] lim = {6'h0, freq_offset_limit, 8'h0};
  wire signed [16:0] cor = {afc_correction[15], afc_correction};
  chk_afc_en_lag: assert property (
    afc_enable == ($past(freq_offset_limit) != 3'h0)) else $error("afc enable wrong");
  chk_afc_off_zero: assert property (
    (freq_offset_limit == 3'h0)[*3] |-> afc_correction == 16'h0) else $error("correction not zero");
  chk_corr_clamp: assert property (
    $past(freq_err_valid) |-> cor <= lim && cor >= -lim) else $error("correction over limit");
  chk_freeze_fsk_only: assert property (
    !$past(fsk_mode && freeze_on_sync_detect) |-> !afc_frozen) else $error("freeze without cause");
  chk_synth_hold: assert property (
    afc_frozen[*3] |-> $stable(synth_freq_word)) else $error("synth moved while frozen");
  chk_synth_center: assert property (
    (!afc_frozen && afc_correction == 16'h0 && $stable(osc_center_freq_word))[*3]
    |-> synth_freq_word == osc_center_freq_word) else $error("synth not at center");
  chk_flag_poll: assert property (
    $rose(sync_detected_flag) |-> $past(self_poll_active)) else $error("flag outside polling");
  chk_oe_scl_low: assert property (
    $changed(sda_oe) |-> !scl) else $error("data pin moved with clock high");
  chk_sda_low: assert property (
    sda_out == 1'b0) else $error("data pin level not low");
  cover property (afc_frozen);
  cover property ($rose(sync_detected_flag));
  cover property ($rose(sda_oe));
endmodule

// [tb/rdc_i2c_host.sv]
// Two-wire bus host model that reaches the configuration bank.
`timescale 1ns/1ps
`include "rdc_defines.vh"
module rdc_i2c_host (
  // Clock.
  input  wire clk,
  // Resolved data line and driven lines.
  input  wire sda,
  output reg  scl,
  output reg  sda_low
);
  integer nak;  // Count of slots where the device gave no acknowledge.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nak = 0;
  end
  // Steps n rising edges, then just past the edge.
  task tk(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bit slot: data set with scl low, sampled late in the high phase.
  task bitx(input b, output r);
    sda_low = !b;
    tk(2);
    scl = 1'b1;
    tk(3);
    r = sda;
    tk(1);
    scl = 1'b0;
    tk(2);
  endtask
  // One byte and its acknowledge slot; a read always ends with a release.
  task xfer(input [7:0] d, input rd, output [7:0] q);
    reg a;
    integer i;
    for (i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, a);
    if (!rd && a) nak++;
  endtask
  // Start and stop conditions.
  task st;
    sda_low = 1'b0;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda_low = 1'b1;
    tk(4);
    scl = 1'b0;
    tk(2);
  endtask
  task sp;
    sda_low = 1'b1;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda_low = 1'b0;
    tk(4);
  endtask
  // Register write: pointer then one data byte.
  task wr(input [7:0] a, input [7:0] d);
    reg [7:0] q;
    st;
    xfer({`RDC_I2C_ADDR, 1'b0}, 1'b0, q);
    xfer(a, 1'b0, q);
    xfer(d, 1'b0, q);
    sp;
  endtask
  // Register read: set the pointer, then fetch one byte.
  task rd(input [7:0] a, output [7:0] d);
    reg [7:0] q;
    st;
    xfer({`RDC_I2C_ADDR, 1'b0}, 1'b0, q);
    xfer(a, 1'b0, q);
    sp;
    st;
    xfer({`RDC_I2C_ADDR, 1'b1}, 1'b0, q);
    xfer(8'hff, 1'b1, d);
    sp;
  endtask
endmodule

// [tb/rdc_config_bank_tb.sv]
// Self-checking testbench of the receiver configuration bank.
`timescale 1ns/1ps
module rdc_config_bank_tb;
  reg         clk, srst, freq_err_valid, chip, chip_valid, self_poll_active, rx_restart;
  reg  [7:0]  signal_strength_in, freq_err_in, demod_filt_in;
  wire        scl, sda_low, sda_out, sda_oe, fsk_mode, if_low_select, threshold_method_select;
  wire        threshold_filter_bandwidth, freeze_on_sync_detect, afc_enable, afc_frozen, sync_detected_flag;
  wire [2:0]  channel_filter_choice, rate_converter_coarse, rate_converter_fine, freq_offset_limit;
  wire [1:0]  freq_loop_gain;
  wire [4:0]  threshold_gain_param;
  wire [3:0]  sync_pattern_len;
  wire [15:0] sync_pattern_word, afc_correction;
  wire [23:0] osc_center_freq_word, synth_freq_word;
  wire        sda = !(sda_low || sda_oe);  // Open-drain line with pull-up.
  integer     error_cnt = 0, n_checks = 0;
  localparam logic [7:0] RST [12] = '{8'h0f, 8'h02, 8'h00, 8'h13, 8'ha9, 8'h9a, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSK [9] = '{8'h7f, 8'h1f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff};
  rdc_config_bank u_dut (.sda_in(sda), .signal_strength_in(signal_strength_in), .freq_err_in(freq_err_in), .demod_filt_in(demod_filt_in),
    .freq_err_valid(freq_err_valid), .chip(chip), .chip_valid(chip_valid), .self_poll_active(self_poll_active),
    .rx_restart(rx_restart), .*);
  rdc_i2c_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  task chk(input string nm, input [23:0] e, input [23:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rchk(input [7:0] a, input [7:0] e);
    reg [7:0] q;
    u_host.rd(a, q);
    chk("register read", e, q);
  endtask
  task finish_test;
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One error estimate pulse.
  task errp(input [7:0] v);
    freq_err_in = v;
    freq_err_valid = 1'b1;
    u_host.tk(1);
    freq_err_valid = 1'b0;
    u_host.tk(4);
  endtask
  // One data bit as two Manchester chips.
  task sbit(input b);
    chip = b;
    chip_valid = 1'b1;
    u_host.tk(1);
    chip_valid = 1'b0;
    u_host.tk(1);
    chip = !b;
    chip_valid = 1'b1;
    u_host.tk(1);
    chip_valid = 1'b0;
    u_host.tk(1);
  endtask
  task t_reset;
    integer i;
    for (i = 0; i < 12; i++) rchk(i < 9 ? 6 + i : 7 + i, RST[i]);
    chk("center word", 24'h13a99a, osc_center_freq_word);
    chk("coarse rate", 3'h2, rate_converter_coarse);
    chk("if select", 1'b0, if_low_select);
  endtask
  task t_afc;
    u_host.wr(8'h07, 8'h07);
    repeat (3) errp(8'h7f);
    chk("correction", 16'h0100, afc_correction);
    chk("synth word", 24'h13aa9a, synth_freq_word);
    repeat (3) errp(8'h80);
    chk("correction", 16'hff00, afc_correction);
    u_host.wr(8'h07, 8'h02);
    chk("correction", 16'h0000, afc_correction);
    u_host.wr(8'h07, 8'h1c);
    errp(8'h7f);
    chk("correction", 16'h001f, afc_correction);
    u_host.wr(8'h07, 8'h1d);
    errp(8'h7f);
    chk("correction", 16'h005e, afc_correction);
  endtask
  task t_sync;
    integer k;
    u_host.wr(8'h02, 8'h18);
    u_host.wr(8'h03, 8'h5b);
    chk("mode fields", 5'h18, {fsk_mode, if_low_select, channel_filter_choice});
    chk("rate fields", 6'h1b, {rate_converter_coarse, rate_converter_fine});
    u_host.wr(8'h08, 8'h40);
    u_host.wr(8'h0c, 8'h03);
    u_host.wr(8'h0d, 8'h0b);
    u_host.wr(8'h0e, 8'hff);
    self_poll_active = 1'b1;
    sbit(0);
    sbit(0);
    sbit(1);
    sbit(1);
    chk("early match", 1'b0, sync_detected_flag);
    chk("frozen early", 1'b0, afc_frozen);
    sbit(0);
    sbit(1);
    sbit(1);
    for (k = 0; k < 20 && sync_detected_flag !== 1'b1; k++) u_host.tk(1);
    chk("sync flag", 1'b1, sync_detected_flag);
    chk("frozen", 1'b1, afc_frozen);
    errp(8'h7f);
    chk("synth word", 24'h13a9f8, synth_freq_word);
    rchk(8'h13, 8'h01);
    rchk(8'h13, 8'h00);
    self_poll_active = 1'b0;
    rx_restart = 1'b1;
    u_host.tk(1);
    rx_restart = 1'b0;
    u_host.tk(2);
    chk("frozen", 1'b0, afc_frozen);
  endtask
  task t_codes;
    integer i;
    for (i = 0; i < 8; i++) begin
      u_host.wr(8'h07, {i[2:0], i[1:0]});
      chk("offset limit", i, freq_offset_limit);
      chk("loop gain", i % 4, freq_loop_gain);
      chk("afc enable", i != 0, afc_enable);
    end
  endtask
  task t_ro;
    signal_strength_in = 8'hc3;
    demod_filt_in = 8'h85;
    errp(8'h9c);
    rchk(8'h10, 8'hc3);
    rchk(8'h11, 8'h9c);
    rchk(8'h12, 8'h85);
    u_host.wr(8'h11, 8'h55);
    rchk(8'h11, 8'h9c);
    rchk(8'h1f, 8'h00);
    chk("missing acks", 0, u_host.nak);
  endtask
  task t_rw;
    integer i, j;
    reg [7:0] v [9];
    for (j = 0; j < 2; j++) begin
      for (i = 0; i < 9; i++) begin
        v[i] = ((j ? 8'h4a : 8'hb5) ^ (i * 8'h11)) & (i == 2 ? 8'hc0 : 8'hff);
        u_host.wr(6 + i, v[i]);
        rchk(6 + i, v[i] & MSK[i]);
      end
      chk("threshold", v[0][6:0], {threshold_method_select, threshold_filter_bandwidth, threshold_gain_param});
      chk("afc fields", v[1][4:0], {freq_offset_limit, freq_loop_gain});
      chk("freeze bit", v[2][6], freeze_on_sync_detect);
      chk("center word", {v[3], v[4], v[5]}, osc_center_freq_word);
      chk("pattern", {v[6][3:0], v[8], v[7]}, {sync_pattern_len, sync_pattern_word});
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    finish_test;
  end
  initial begin
    {srst, freq_err_valid, chip, chip_valid, self_poll_active, rx_restart} = 6'h20;
    {signal_strength_in, freq_err_in, demod_filt_in} = 24'h0;
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    u_host.tk(2);
    t_reset;
    t_afc;
    t_sync;
    t_codes;
    t_ro;
    t_rw;
    finish_test;
  end
endmodule
bind rdc_config_bank rdc_config_bank_assertions u_chk (.*);
